//--- rtl/nbr_hold_reg.v
// Nine-bit edge-loaded holding register with clear and three-state drive.
// Assumes all control and data pins are asynchronous to clk_i.
// Notes on behaviour
// - Nine separate storage bits, each with its own input and output, load on a clock edge.
// - Clock, load gate and output enable are shared by all nine bits.
// - A rising edge_clock with load gate low and clear_n high captures the inputs.
// - With load gate high and clear_n high the stored bits never change on a clock edge.
// - With output enable low each output drives its stored bit.
// - With output enable high all nine outputs float.
// - Output enable has no effect on storage; loads and clears go on while floating.
// - While clear_n is low all bits are forced to zero, overriding clock, gate and data.
// - Outputs are true, never inverted.
`timescale 1ns/1ps
`include "nbr_regs.vh"

module nbr_hold_reg (
   input wire clk_i,
   input wire rst_n_i,
   input wire edge_clock_i,
   input wire load_n_i,
   input wire clear_n_i,
   input wire oe_n_i,
   input wire [`NBR_WIDTH-1:0] bit_inputs_i,
   output reg [`NBR_WIDTH-1:0] bus_drive_o,
   output reg [`NBR_WIDTH-1:0] bus_drive_oe_n_o
);

   // Edge tracker states
   localparam [0:0] ST_LOW = 1'h0;
   localparam [0:0] ST_HIGH = 1'h1;

   // Reset images of the filtered pins and the cleared storage
   localparam [`NBR_PINS-1:0] PIN_RST = `NBR_PINS_RST;
   localparam [`NBR_WIDTH-1:0] DATA_RST = PIN_RST[`NBR_F_DATA_MSB:`NBR_F_DATA_LSB];
   localparam [`NBR_PINS-`NBR_WIDTH-1:0] CTRL_RST = PIN_RST[`NBR_PINS-1:`NBR_F_EDGE];
   localparam [`NBR_WIDTH-1:0] CLEARED_VAL = `NBR_CLEARED;

   // Raw pins regrouped for the two filters
   wire [`NBR_PINS-`NBR_WIDTH-1:0] ctrl_pins;
   wire [`NBR_WIDTH-1:0] data_pins;

   // Filtered pin levels, all on clk_i
   wire [`NBR_PINS-`NBR_WIDTH-1:0] ctrl_lvl;
   wire [`NBR_WIDTH-1:0] data_filt;
   wire [`NBR_PINS-1:0] level;
   wire [`NBR_WIDTH-1:0] data_lvl;
   wire edge_lvl;
   wire load_n_lvl;
   wire clear_n_lvl;
   wire oe_n_lvl;

   // Edge tracker
   reg edge_state;
   reg next_edge_state;
   reg rise;

   // Shared controls, one set for all nine bits
   reg load_strobe;
   reg clear_force;

   // Per-bit next values
   wire [`NBR_WIDTH-1:0] next_q;
   wire [`NBR_WIDTH-1:0] next_oe_n;

   assign ctrl_pins = {oe_n_i, clear_n_i, load_n_i, edge_clock_i};
   assign data_pins = bit_inputs_i;

   // Both filters have the same depth, so data stays aligned with the detected edge
   nbr_pin_filter #(
      .WIDTH(`NBR_PINS - `NBR_WIDTH),
      .RST_VAL(CTRL_RST)
   ) u_ctrl_filter (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(ctrl_pins),
      .level_o(ctrl_lvl)
   );

   nbr_pin_filter #(
      .WIDTH(`NBR_WIDTH),
      .RST_VAL(DATA_RST)
   ) u_data_filter (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(data_pins),
      .level_o(data_filt)
   );

   assign level = {ctrl_lvl, data_filt};
   assign data_lvl = level[`NBR_F_DATA_MSB:`NBR_F_DATA_LSB];
   assign edge_lvl = level[`NBR_F_EDGE];
   assign load_n_lvl = level[`NBR_F_LOAD_N];
   assign clear_n_lvl = level[`NBR_F_CLEAR_N];
   assign oe_n_lvl = level[`NBR_F_OE_N];

   // Edge tracker: a rise is a filtered low-to-high step of edge_clock
   always @* begin
      next_edge_state = edge_state;
      rise = 1'h0;
      case (edge_state)
         ST_LOW: begin
            if (edge_lvl) begin
               next_edge_state = ST_HIGH;
               rise = 1'h1;
            end
         end
         ST_HIGH: begin
            if (!edge_lvl) begin
               next_edge_state = ST_LOW;
            end
         end
         default: begin
            next_edge_state = ST_LOW;
         end
      endcase
   end

   // Starts low like the idle pin, so no false rise follows reset
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         edge_state <= ST_LOW;
      end else begin
         edge_state <= next_edge_state;
      end
   end

   // Clear overrides a load in the same cycle; output enable never takes part
   always @* begin
      clear_force = 1'h0;
      load_strobe = 1'h0;
      if (!clear_n_lvl) begin
         clear_force = 1'h1;
      end else if (rise && !load_n_lvl) begin
         load_strobe = 1'h1;
      end else begin
         load_strobe = 1'h0;
      end
   end

   // One loop builds each bit's storage input and its output enable
   genvar b;
   generate
      for (b = 0; b < `NBR_WIDTH; b = b + 1) begin : g_bit
         reg next_bit;
         always @* begin
            if (clear_force) begin
               next_bit = CLEARED_VAL[b];
            end else if (load_strobe) begin
               next_bit = data_lvl[b];
            end else begin
               next_bit = bus_drive_o[b];
            end
         end
         assign next_q[b] = next_bit;
         assign next_oe_n[b] = oe_n_lvl;
      end
   endgenerate

   // Storage is left out of reset on purpose: content is unknown until cleared or loaded
   always @(posedge clk_i) begin
      bus_drive_o <= next_q;
   end

   // Outputs float during reset so a shared bus is not disturbed
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         bus_drive_oe_n_o <= `NBR_OE_N_RST;
      end else begin
         bus_drive_oe_n_o <= next_oe_n;
      end
   end

endmodule // nbr_hold_reg

//--- rtl/nbr_regs.vh
// Constants for the nine-bit three-state holding register.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef NBR_REGS_VH
`define NBR_REGS_VH

// Storage width and pin sampling depth
`define NBR_WIDTH 9
`define NBR_SYNC_STAGES 3

// Packed pin vector field positions
`define NBR_F_DATA_LSB 0
`define NBR_F_DATA_MSB 8
`define NBR_F_EDGE 9
`define NBR_F_LOAD_N 10
`define NBR_F_CLEAR_N 11
`define NBR_F_OE_N 12
`define NBR_PINS 13

// Reset values of the filtered pin levels: idle, not loading, not clearing, floated
`define NBR_PINS_RST 13'h1C00
`define NBR_CLEARED 9'h000
`define NBR_OE_N_RST 9'h1FF

// Cycles from a pin change to its filtered level
`define NBR_FILT_LAT 4

`endif

//--- rtl/nbr_pin_filter.v
// Three-stage pin sampler with agreement filter, one per pin.
// Assumes pins are asynchronous to clk_i; reset is synchronous, active low.
`timescale 1ns/1ps
`include "nbr_regs.vh"

module nbr_pin_filter #(
   parameter WIDTH = `NBR_PINS,
   parameter [WIDTH-1:0] RST_VAL = `NBR_PINS_RST
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire [WIDTH-1:0] pin_i,
   output wire [WIDTH-1:0] level_o
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
         reg s1;
         reg s2;
         reg s3;
         reg level;
         always @(posedge clk_i) begin
            if (!rst_n_i) begin
               s1 <= RST_VAL[g];
               s2 <= RST_VAL[g];
               s3 <= RST_VAL[g];
               level <= RST_VAL[g];
            end else begin
               s1 <= pin_i[g];
               s2 <= s1;
               s3 <= s2;
               // Only stages two and three are compared; stage one may be metastable
               if (s2 == s3) begin
                  level <= s3;
               end
            end
         end
         assign level_o[g] = level;
      end
   endgenerate

endmodule // nbr_pin_filter

//--- testbench/nbr_chk.sv
// Port checker; assumes a bind to nbr_hold_reg and a five-edge pin latency.
`timescale 1ns/1ps
module nbr_chk (
   input wire clk_i,
   input wire rst_n_i,
   input wire edge_clock_i,
   input wire load_n_i,
   input wire clear_n_i,
   input wire oe_n_i,
   input wire [8:0] bit_inputs_i,
   input wire [8:0] bus_drive_o,
   input wire [8:0] bus_drive_oe_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_ld; clear_n_i && !load_n_i && $rose(edge_clock_i); endsequence
   chk_load_take: assert property (s_ld |-> ##6 bus_drive_o == $past(bit_inputs_i, 6))
      else $error("load lost");
   chk_gate_hold: assert property ((load_n_i && clear_n_i)[*7] |-> $stable(bus_drive_o))
      else $error("hold moved");
   chk_gate_edge: assert property (load_n_i && $rose(edge_clock_i) |-> ##6 $stable(bus_drive_o))
      else $error("gated load");
   chk_clr_zero: assert property ((!clear_n_i)[*7] |-> !bus_drive_o)
      else $error("no clear");
   chk_clr_wins: assert property (!clear_n_i && $rose(edge_clock_i) |-> ##6 !bus_drive_o)
      else $error("clear lost");
   chk_oe_on: assert property ((!oe_n_i)[*7] |-> !bus_drive_oe_n_o) else $error("not on");
   chk_oe_off: assert property (oe_n_i[*7] |-> &bus_drive_oe_n_o) else $error("not off");
   chk_oe_same: assert property (!bus_drive_oe_n_o || &bus_drive_oe_n_o)
      else $error("split");
endmodule // nbr_chk
bind nbr_hold_reg nbr_chk u_chk (.*);

//--- testbench/nbr_bus_model.sv
// Far-side bus; assumes per-bit enables, low while driving.
`timescale 1ns/1ps
module nbr_bus_model (
   input wire [8:0] drive_i,
   input wire [8:0] oe_n_i,
   output wire [8:0] bus_o
);
   // Floated bits read inverted, so a stale value never passes
   assign bus_o = drive_i ^ oe_n_i;
endmodule // nbr_bus_model

//--- testbench/nbr_hold_reg_tb_top.sv
// Corner and random traffic; assumes the bus model and bound checker.
`timescale 1ns/1ps
module nbr_hold_reg_tb_top;
   reg clk_i = 0, rst_n_i = 0, edge_clock_i = 0, load_n_i = 1, clear_n_i = 0, oe_n_i = 1;
   reg [8:0] bit_inputs_i = 9'h000, qx = 9'h000;
   wire [8:0] bus_drive_o, bus_drive_oe_n_o, bus;
   integer fails = 0, samples_checked = 0;
   nbr_hold_reg DUT (.*);
   nbr_bus_model BUS (.drive_i(bus_drive_o), .oe_n_i(bus_drive_oe_n_o), .bus_o(bus));
   function [8:0] nxt(input [31:0] r);
      nxt = ~|r[11:10] ? 9'h000 : (r[9] ? qx : r[8:0]);
   endfunction
   task check_q(input [8:0] e);
      samples_checked = samples_checked + 1;
      fails = fails + (bus_drive_o !== e);
      if (bus_drive_o !== e) $display("unexpected q: expected %h seen %h", e, bus_drive_o);
   endtask
   task check_en(input [8:0] e);
      samples_checked = samples_checked + 1;
      fails = fails + (bus_drive_oe_n_o !== e);
      if (bus_drive_oe_n_o !== e)
         $display("unexpected en: expected %h seen %h", e, bus_drive_oe_n_o);
   endtask
   task check_bus(input [8:0] e);
      samples_checked = samples_checked + 1;
      fails = fails + (bus !== e);
      if (bus !== e) $display("unexpected bus: expected %h seen %h", e, bus);
   endtask
   task conclude;
      $display("fails %0d samples_checked %0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Pins settle before the edge; the filter drops short pulses
   task step(input [31:0] r);
      @(posedge clk_i) {oe_n_i, clear_n_i, load_n_i, bit_inputs_i, edge_clock_i}
         <= {r[12], |r[11:10], r[9:0], 1'b0};
      repeat (4) @(posedge clk_i);
      edge_clock_i <= 1'b1;
      qx = nxt(r);
      repeat (12) @(posedge clk_i);
      #1 check_q(qx);
      check_en({9{oe_n_i}});
      if (!oe_n_i) check_bus(qx);
   endtask
   initial forever #5 clk_i = ~clk_i;
   initial begin
      #20000 fails = fails + 1;
      conclude;
   end
   initial begin
      void'($urandom(88));
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      step(32'h1200);
      step(32'h15FF);
      step(32'h0600);
      step(32'h00AA);
      repeat (40) step($urandom);
      conclude;
   end
endmodule // nbr_hold_reg_tb_top
